// file: updown_timer_counter_core.v
// apb-attached up/down timer counter core with quadrature, trigger and cascade control
`timescale 1ns/1ps
`include "timer_core_map.vh"
module updown_timer_counter_core #(
    parameter WIDTH = 16
) (
    // clock, reset, enable
    input wire clock,
    input wire rstn,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // channel inputs, from pin or reflex channel
    input wire channel0_pin,
    input wire channel1_pin,
    // neighbour timers
    input wire nbr_start,
    input wire nbr_stop,
    input wire nbr_reload,
    input wire nbr_overflow,
    input wire nbr_underflow,
    // events and state towards compare/capture and neighbours
    output reg overflow_q,
    output reg underflow_q,
    output reg update_q,
    output reg ext_start_q,
    output reg ext_stop_q,
    output reg ext_reload_q,
    output reg ch1_capture_q,
    output reg [WIDTH-1:0] counter_value_q
);
    reg r1_q;
    reg rst_n;
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            r1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            r1_q <= 1'b1;
            rst_n <= r1_q;
        end
    end

    wire ch0_lvl;
    wire ch1_lvl;
    pin_sync3 u_sync0 (.clock(clock), .rst_n(rst_n), .en(clk_en), .pin(channel0_pin), .level_q(ch0_lvl));
    pin_sync3 u_sync1 (.clock(clock), .rst_n(rst_n), .en(clk_en), .pin(channel1_pin), .level_q(ch1_lvl));

    // registers
    reg [1:0] mode_q;
    reg follow_q;
    reg quad_decode_select_q;
    reg one_shot_enable_q;
    reg [1:0] rising_edge_action_q;
    reg [1:0] falling_edge_action_q;
    reg [1:0] count_source_select_q;
    reg [1:0] ch1_edge_q;
    reg double_step_enable_q;
    reg [3:0] prescale_exponent_q;
    reg [WIDTH-1:0] count_limit_q;
    reg [WIDTH-1:0] count_limit_buffer_q;
    reg limit_buffer_valid_q;
    reg running_q;
    reg dir_down_q;
    reg [9:0] prescale_exponent_cnt_q;
    reg ch0_prev_q;
    reg ch1_prev_q;

    wire [31:0] ctrl_word = {4'h0, prescale_exponent_q, 2'h0, ch1_edge_q, 1'b0, double_step_enable_q,
        count_source_select_q, 4'h0, falling_edge_action_q, rising_edge_action_q,
        2'h0, one_shot_enable_q, quad_decode_select_q, follow_q, 1'b0, mode_q};

    // apb decode; every access completes one cycle after its first access cycle
    wire acc = psel && penable && !pready;
    wire wr = acc && pwrite;
    wire wr_ctrl = wr && (paddr == `OFS_CTRL);
    wire wr_cmd = wr && (paddr == `OFS_CMD);
    wire wr_limit = wr && (paddr == `OFS_LIMIT);
    wire wr_limitb = wr && (paddr == `OFS_LIMITB);
    wire wr_count = wr && (paddr == `OFS_COUNT);
    reg mapped;
    reg [31:0] rd_mux;
    always @* begin
        mapped = 1'b1;
        rd_mux = 32'h0;
        if (paddr == `OFS_CTRL) begin
            rd_mux = ctrl_word;
        end else if (paddr == `OFS_CMD) begin
            rd_mux = 32'h0;
        end else if (paddr == `OFS_STATUS) begin
            rd_mux = {29'h0, limit_buffer_valid_q, dir_down_q, running_q};
        end else if (paddr == `OFS_LIMIT) begin
            rd_mux[WIDTH-1:0] = count_limit_q;
        end else if (paddr == `OFS_LIMITB) begin
            rd_mux[WIDTH-1:0] = count_limit_buffer_q;
        end else if (paddr == `OFS_COUNT) begin
            rd_mux[WIDTH-1:0] = counter_value_q;
        end else begin
            mapped = 1'b0;
        end
    end

    // channel edges
    wire ch0_rise = ch0_lvl && !ch0_prev_q;
    wire ch0_fall = !ch0_lvl && ch0_prev_q;
    wire ch1_rise = ch1_lvl && !ch1_prev_q;
    wire ch1_fall = !ch1_lvl && ch1_prev_q;

    // channel 0 edge actions
    wire [1:0] act = ch0_rise ? rising_edge_action_q : (ch0_fall ? falling_edge_action_q : `ACT_NONE);
    wire loc_start = (act == `ACT_START) || (act == `ACT_RELOAD);
    wire loc_stop = (act == `ACT_STOP);
    wire loc_reload = (act == `ACT_RELOAD);
    wire do_start = loc_start || (follow_q && (nbr_start || nbr_reload)) || (wr_cmd && pwdata[`CMD_START]);
    wire do_stop = loc_stop || (follow_q && nbr_stop) || (wr_cmd && pwdata[`CMD_STOP]);
    wire do_reload = loc_reload || (follow_q && nbr_reload);

    // prescaler tick: 2^exponent clock cycles per step
    wire [9:0] prescale_exponent_mask = (10'h001 << prescale_exponent_q) - 10'h001;
    wire prescale_exponent_tick = running_q && ((prescale_exponent_cnt_q & prescale_exponent_mask) == prescale_exponent_mask);

    // quadrature step and direction
    reg q_step;
    reg q_down;
    always @* begin
        q_step = 1'b0;
        q_down = 1'b0;
        if (ch0_rise || ch0_fall) begin
            q_step = 1'b1;
            q_down = ch0_rise ? ch1_lvl : !ch1_lvl;
        end else if (quad_decode_select_q && (ch1_rise || ch1_fall)) begin
            q_step = 1'b1;
            q_down = ch1_rise ? !ch0_lvl : ch0_lvl;
        end
    end

    wire ch1_clk_edge = ((ch1_edge_q == `CH1_EDGE_RISE) && ch1_rise) || ((ch1_edge_q == `CH1_EDGE_FALL) && ch1_fall)
        || ((ch1_edge_q == `CH1_EDGE_BOTH) && (ch1_rise || ch1_fall));
    reg src_step;
    always @* begin
        case (count_source_select_q)
            `SRC_PRESCALE_EXPONENT: src_step = prescale_exponent_tick;
            `SRC_CH1: src_step = ch1_clk_edge && running_q;
            `SRC_CASCADE: src_step = running_q && (nbr_overflow || nbr_underflow);
            default: src_step = 1'b0;
        endcase
    end
    wire is_quad = (mode_q == `MODE_QDEC);
    wire step = is_quad ? (running_q && q_step) : src_step;
    wire step_down = is_quad ? q_down : dir_down_q;

    // next-value arithmetic
    wire [WIDTH-1:0] inc = double_step_enable_q ? {{(WIDTH-2){1'b0}}, 2'h2} : {{(WIDTH-1){1'b0}}, 1'b1};
    wire [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
    wire at_limit = (counter_value_q == count_limit_q);
    wire at_zero = (counter_value_q == {WIDTH{1'b0}});
    wire ovf = step && !step_down && at_limit;
    wire unf = step && step_down && at_zero;
    reg upd;
    always @* begin
        case (mode_q)
            `MODE_UP: upd = ovf;
            `MODE_QDEC: upd = ovf || unf;
            default: upd = unf;
        endcase
    end
    wire [WIDTH-1:0] reload_val = (mode_q == `MODE_DOWN) ? count_limit_q : {WIDTH{1'b0}};
    wire os_stop = upd && one_shot_enable_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= `MODE_UP;
            follow_q <= 1'b0;
            quad_decode_select_q <= 1'b0;
            one_shot_enable_q <= 1'b0;
            rising_edge_action_q <= `ACT_NONE;
            falling_edge_action_q <= `ACT_NONE;
            count_source_select_q <= `SRC_PRESCALE_EXPONENT;
            ch1_edge_q <= `CH1_EDGE_RISE;
            double_step_enable_q <= 1'b0;
            prescale_exponent_q <= 4'h0;
            count_limit_q <= {WIDTH{1'b1}};
            count_limit_buffer_q <= {WIDTH{1'b0}};
            limit_buffer_valid_q <= 1'b0;
            running_q <= 1'b0;
            dir_down_q <= 1'b0;
            prescale_exponent_cnt_q <= 10'h000;
            ch0_prev_q <= 1'b0;
            ch1_prev_q <= 1'b0;
            counter_value_q <= {WIDTH{1'b0}};
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            overflow_q <= 1'b0;
            underflow_q <= 1'b0;
            update_q <= 1'b0;
            ext_start_q <= 1'b0;
            ext_stop_q <= 1'b0;
            ext_reload_q <= 1'b0;
            ch1_capture_q <= 1'b0;
        end else if (clk_en) begin
            ch0_prev_q <= ch0_lvl;
            ch1_prev_q <= ch1_lvl;
            pready <= acc;
            pslverr <= acc && !mapped;
            if (acc && !pwrite) begin
                prdata <= mapped ? rd_mux : 32'h0;
            end
            if (wr_ctrl) begin
                mode_q <= pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB];
                follow_q <= pwdata[`CTRL_FOLLOW];
                quad_decode_select_q <= pwdata[`CTRL_QDM];
                one_shot_enable_q <= pwdata[`CTRL_OSM];
                rising_edge_action_q <= pwdata[`CTRL_RISE_LSB+1:`CTRL_RISE_LSB];
                falling_edge_action_q <= pwdata[`CTRL_FALL_LSB+1:`CTRL_FALL_LSB];
                count_source_select_q <= pwdata[`CTRL_SRC_LSB+1:`CTRL_SRC_LSB];
                ch1_edge_q <= pwdata[`CTRL_CH1EDGE_LSB+1:`CTRL_CH1EDGE_LSB];
                double_step_enable_q <= pwdata[`CTRL_X2];
                prescale_exponent_q <= (pwdata[`CTRL_PRESCALE_EXPONENT_LSB+3:`CTRL_PRESCALE_EXPONENT_LSB] > `PRESCALE_EXPONENT_MAX) ?
                    `PRESCALE_EXPONENT_MAX : pwdata[`CTRL_PRESCALE_EXPONENT_LSB+3:`CTRL_PRESCALE_EXPONENT_LSB];
            end
            // events
            overflow_q <= ovf;
            underflow_q <= unf;
            update_q <= upd;
            ext_start_q <= loc_start;
            ext_stop_q <= loc_stop;
            ext_reload_q <= loc_reload;
            ch1_capture_q <= (count_source_select_q == `SRC_CH1) && ch1_clk_edge && !os_stop;
            // run control; a stop wins over a start in the same cycle
            if (do_stop || os_stop) begin
                running_q <= 1'b0;
            end else if (do_start) begin
                running_q <= 1'b1;
            end
            if (!running_q || do_stop || os_stop) begin
                prescale_exponent_cnt_q <= 10'h000;
            end else begin
                prescale_exponent_cnt_q <= prescale_exponent_tick ? 10'h000 : prescale_exponent_cnt_q + 10'h001;
            end
            // limit and its buffer; a buffer write in the update cycle stays pending
            if (wr_limit) begin
                count_limit_q <= pwdata[WIDTH-1:0];
                limit_buffer_valid_q <= 1'b0;
            end else if (wr_limitb) begin
                count_limit_buffer_q <= pwdata[WIDTH-1:0];
                limit_buffer_valid_q <= 1'b1;
            end else if (upd && limit_buffer_valid_q) begin
                count_limit_q <= count_limit_buffer_q;
                limit_buffer_valid_q <= 1'b0;
            end
            // counter: software write beats reload, reload beats a step
            if (wr_count) begin
                counter_value_q <= pwdata[WIDTH-1:0];
                if (mode_q == `MODE_UPDOWN) begin
                    dir_down_q <= 1'b0;
                end
            end else if (do_reload) begin
                counter_value_q <= reload_val;
                dir_down_q <= (mode_q == `MODE_DOWN);
            end else if (step) begin
                if (is_quad) begin
                    dir_down_q <= step_down;
                end
                if (ovf) begin
                    if (mode_q == `MODE_UPDOWN) begin
                        counter_value_q <= count_limit_q - one;
                        dir_down_q <= 1'b1;
                    end else begin
                        counter_value_q <= {WIDTH{1'b0}};
                    end
                end else if (unf) begin
                    if (mode_q == `MODE_UPDOWN) begin
                        counter_value_q <= one;
                        dir_down_q <= 1'b0;
                    end else begin
                        counter_value_q <= count_limit_q;
                    end
                end else if (step_down) begin
                    counter_value_q <= (counter_value_q < inc) ? {WIDTH{1'b0}} : counter_value_q - inc;
                end else begin
                    counter_value_q <= ((count_limit_q - counter_value_q) < inc) ? count_limit_q
                        : counter_value_q + inc;
                end
            end else if (wr_ctrl && !running_q) begin
                // entering a mode sets its starting direction
                dir_down_q <= (pwdata[`CTRL_MODE_LSB+1:`CTRL_MODE_LSB] == `MODE_DOWN);
            end
        end
    end
endmodule // updown_timer_counter_core

// file: timer_core_map.vh
// register offsets, field positions, encodings and reset values of the timer counter core
// How it works
// - up mode counts to the limit, then wraps to zero and continues
// - down mode starts at the limit, reloads the limit after zero
// - up/down mode reverses at the limit and again at zero
// - quadrature mode uses channel 0 as A, channel 1 as B; X2/X4 selectable
// - double step enable makes each step change the count by two, stopping at the limit or zero instead of passing it
// - counter readable and writable anytime; write in up/down forces direction up
// - overflow when leaving the limit upward; next zero, or limit minus one
// - underflow when leaving zero downward; next limit, or one in up/down
// - update event on overflow (up), underflow (down, up/down), both (quadrature)
// - start and stop commands; running and direction status bits readable
// - rising and falling channel 0 edge fields pick start, stop or reload
// - reload loads zero in up and up/down modes, the limit in down mode
// - follow bit makes the timer copy neighbour start, stop and reload actions
// - prescaler divides by two to the exponent 0..10; cleared while stopped
// - channel 1 rising, falling or both edges may clock the counter
// - a channel 0 edge that starts the timer does not also step it
// - timer can count on neighbour overflow or underflow to form chained counters
// - one shot stops the counter on the first update event
// - the channel 1 edge that stops a one-shot timer raises no capture
// - limit buffer moves into the limit at update; valid flag until then
// - direct limit write cancels the pending buffer and clears its valid flag
// - X4 steps on every edge of A and B, direction from the other channel
`ifndef TIMER_CORE_MAP_VH
`define TIMER_CORE_MAP_VH
`define OFS_CTRL 12'h000
`define OFS_CMD 12'h004
`define OFS_STATUS 12'h008
`define OFS_LIMIT 12'h00c
`define OFS_LIMITB 12'h010
`define OFS_COUNT 12'h014
// control field positions
`define CTRL_MODE_LSB 0
`define CTRL_FOLLOW 3
`define CTRL_QDM 4
`define CTRL_OSM 5
`define CTRL_RISE_LSB 8
`define CTRL_FALL_LSB 10
`define CTRL_SRC_LSB 16
`define CTRL_X2 18
`define CTRL_PRESCALE_EXPONENT_LSB 24
// command and status bits
`define CMD_START 0
`define CMD_STOP 1
`define STAT_RUN 0
`define STAT_DIR 1
`define STAT_LBV 2
// modes
`define MODE_UP 2'h0
`define MODE_DOWN 2'h1
`define MODE_UPDOWN 2'h2
`define MODE_QDEC 2'h3
// edge actions
`define ACT_NONE 2'h0
`define ACT_START 2'h1
`define ACT_STOP 2'h2
`define ACT_RELOAD 2'h3
// count sources
`define SRC_PRESCALE_EXPONENT 2'h0
`define SRC_CH1 2'h1
`define SRC_CASCADE 2'h2
// edge select for channel 1 clocking
`define CH1_EDGE_RISE 2'h1
`define CH1_EDGE_FALL 2'h2
`define CH1_EDGE_BOTH 2'h3
`define CTRL_CH1EDGE_LSB 20
`define PRESCALE_EXPONENT_MAX 4'ha
`define LIMIT_RESET 32'hffffffff
`endif

// file: pin_sync3.v
// three-stage synchroniser with agreement check for external inputs
`timescale 1ns/1ps
module pin_sync3 (
    // clock and reset
    input wire clock,
    input wire rst_n,
    input wire en,
    // pin side
    input wire pin,
    // synchronised level
    output reg level_q
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
        end else if (en) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // first stage feeds only the second; change taken once stages two and three agree
            if (s2_q == s3_q) begin
                level_q <= s3_q;
            end
        end
    end
endmodule // pin_sync3

// file: updown_timer_counter_core_chk.sv
// port checker for the timer counter core
`timescale 1ns/1ps
module updown_timer_counter_core_chk #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire clock,
    input wire rstn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // events and count
    input wire overflow_q,
    input wire underflow_q,
    input wire update_q,
    input wire [WIDTH-1:0] counter_value_q
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    a_one_wait: assert property (s_access |=> s_answer) else $error("apb answer late or long");
    a_ready_cause: assert property ($rose(pready) |-> $past(psel && penable)) else $error("stray pready");
    a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("pready in setup");
    a_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
    a_update_cause: assert property (update_q |-> overflow_q || underflow_q) else $error("update without wrap");
    a_wrap_apart: assert property (!(overflow_q && underflow_q)) else $error("both wraps at once");
    a_reset_clear: assert property (disable iff (1'b0) !rstn ##1 !rstn |-> counter_value_q == 0 && !update_q)
        else $error("reset not clearing");
endmodule // updown_timer_counter_core_chk
bind updown_timer_counter_core updown_timer_counter_core_chk #(.WIDTH(WIDTH)) chk_u (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overflow_q(overflow_q), .underflow_q(underflow_q),
    .update_q(update_q), .counter_value_q(counter_value_q));

// file: quad_encoder_model.sv
// quadrature encoder on the channel 0 and channel 1 pins
`timescale 1ns/1ps
module quad_encoder_model (
    // clock
    input wire clock,
    // encoder phases
    output reg chan_a,
    output reg chan_b
);
    reg [1:0] phase_q = 2'h0;
    initial begin
        chan_a = 1'b0;
        chan_b = 1'b0;
    end
    // a leads b when moving up; nine cycles a quarter keeps the rate well below a third of the clock
    task step(input up);
        begin
            phase_q = up ? phase_q + 2'h1 : phase_q - 2'h1;
            @(posedge clock);
            chan_a <= phase_q[0] ^ phase_q[1];
            chan_b <= phase_q[1];
            repeat (8) @(posedge clock);
        end
    endtask
endmodule // quad_encoder_model

// file: updown_timer_counter_core_tb_top.sv
// self-checking bench for the timer counter core
`timescale 1ns/1ps
`include "timer_core_map.vh"
module updown_timer_counter_core_tb_top;
    reg clock = 1'b0;
    reg rstn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [2:0] nbr_q = 3'h0;
    reg nbr_overflow = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, overflow_q, underflow_q, update_q, chan_a, chan_b;
    wire [15:0] counter_value_q;
    wire ext_start_q, ext_stop_q, ext_reload_q, ch1_capture_q;
    integer n_start = 0;
    integer n_stop = 0;
    integer n_reload = 0;
    integer n_capt = 0;
    integer seed = 32'h0b706540;
    integer fail_count = 0;
    integer n_checks = 0;
    integer i;
    integer k;
    logic [32:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [32:0] e;
    logic [31:0] m;
    reg [31:0] r;
    logic [31:0] ctl_t [5] = '{32'h03000020, 32'h03000021, 32'h03000022, 32'h03040020, 32'h00020020};
    logic [3:0] st_t [5] = '{4'h3, 4'h2, 4'h4, 4'h2, 4'h3};
    logic [3:0] ex_t [5] = '{4'h0, 4'h5, 4'h1, 4'h0, 4'h0};
    logic dn_t [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    always #10 clock = ~clock;
    updown_timer_counter_core #(.WIDTH(16)) dut_u (
        .clock(clock), .rstn(rstn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .channel0_pin(chan_a), .channel1_pin(chan_b), .nbr_start(nbr_q[0]), .nbr_stop(nbr_q[1]),
        .nbr_reload(nbr_q[2]), .nbr_overflow(nbr_overflow), .nbr_underflow(1'b0),
        .overflow_q(overflow_q), .underflow_q(underflow_q), .update_q(update_q), .ext_start_q(ext_start_q),
        .ext_stop_q(ext_stop_q), .ext_reload_q(ext_reload_q), .ch1_capture_q(ch1_capture_q),
        .counter_value_q(counter_value_q));
    quad_encoder_model enc_u (.clock(clock), .chan_a(chan_a), .chan_b(chan_b));
    // neighbour commands must have no effect while the follow bit stays clear
    always @(posedge clock) nbr_q <= $random(seed);
    // event pulses towards neighbours and capture logic are tallied for the edge action test
    always @(posedge clock) begin
        if (ext_start_q === 1'b1)
            n_start <= n_start + 1;
        if (ext_stop_q === 1'b1)
            n_stop <= n_stop + 1;
        if (ext_reload_q === 1'b1)
            n_reload <= n_reload + 1;
        if (ch1_capture_q === 1'b1)
            n_capt <= n_capt + 1;
    end
    task chk(input [63:0] nm, input integer ex, input integer seen);
        begin
            n_checks = n_checks + 1;
            if (seen !== ex) begin
                $display("Error %0s expected %0d seen %0d", nm, ex, seen);
                fail_count = fail_count + 1;
            end
        end
    endtask
    // answers are compared in order against the notes left by the driver
    always @(posedge clock) begin
        if (pready === 1'b1) begin
            e = exp_q.pop_front();
            m = msk_q.pop_front();
            n_checks = n_checks + 1;
            if ({pslverr, prdata & m} !== e) begin
                $display("Error apb %h expected %h seen %h", paddr, e, {pslverr, prdata & m});
                fail_count = fail_count + 1;
            end
        end
    end
    task conclude;
        begin
            $display("checks %0d mismatches %0d", n_checks, fail_count);
            if (fail_count == 0 && n_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d, input [32:0] ex, input [31:0] mk);
        integer t;
        begin
            exp_q.push_back(ex);
            msk_q.push_back(mk);
            @(posedge clock);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clock);
            penable <= 1'b1;
            t = 0;
            do begin
                @(posedge clock);
                t = t + 1;
            end while (pready !== 1'b1 && t < 50);
            psel <= 1'b0;
            penable <= 1'b0;
            if (t >= 50) begin
                $display("Error apb wait expected pready seen none");
                fail_count = fail_count + 1;
                conclude;
            end
        end
    endtask
    task wr(input [11:0] a, input [31:0] d);
        apb(1'b1, a, d, 33'h0, 32'h0);
    endtask
    task rd(input [11:0] a, input [31:0] ex);
        apb(1'b0, a, 32'h0, {1'b0, ex}, 32'hffffffff);
    endtask
    // cascade pulses come every fourth cycle so a one-shot stop lands before the next step
    task run_until_update(input casc);
        integer t;
        begin
            t = 0;
            while (update_q !== 1'b1 && t < 400) begin
                @(posedge clock);
                nbr_overflow <= casc && (t % 4 == 0);
                t = t + 1;
            end
            nbr_overflow <= 1'b0;
            if (t >= 400) begin
                $display("Error update expected 1 seen 0");
                fail_count = fail_count + 1;
                conclude;
            end
        end
    endtask
    initial begin
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        repeat (4) @(posedge clock);
        rd(`OFS_CTRL, 32'h00100000);
        rd(`OFS_LIMIT, 32'h0000ffff);
        rd(`OFS_STATUS, 32'h0);
        apb(1'b0, 12'h020, 32'h0, 33'h100000000, 32'hffffffff);
        r = $random(seed);
        wr(`OFS_COUNT, r);
        rd(`OFS_COUNT, {16'h0, r[15:0]});
        $display("test access done");
        for (i = 0; i < 5; i = i + 1) begin
            wr(`OFS_CTRL, ctl_t[i]);
            wr(`OFS_LIMIT, 32'h5);
            wr(`OFS_COUNT, {28'h0, st_t[i]});
            wr(`OFS_CMD, 32'h1);
            rd(`OFS_STATUS, {30'h0, dn_t[i], 1'b1});
            run_until_update(i == 4);
            repeat (20) @(posedge clock);
            rd(`OFS_COUNT, {28'h0, ex_t[i]});
            rd(`OFS_STATUS, {30'h0, dn_t[i], 1'b0});
        end
        $display("test modes done");
        wr(`OFS_CTRL, 32'h03000020);
        wr(`OFS_LIMITB, 32'h7);
        rd(`OFS_STATUS, 32'h4);
        wr(`OFS_LIMIT, 32'h9);
        rd(`OFS_STATUS, 32'h0);
        rd(`OFS_LIMIT, 32'h9);
        r = $random(seed);
        r = {28'h0, r[3:0] | 4'h1};
        wr(`OFS_LIMITB, r);
        wr(`OFS_COUNT, 32'h9);
        wr(`OFS_CMD, 32'h1);
        run_until_update(1'b0);
        repeat (4) @(posedge clock);
        rd(`OFS_LIMIT, r);
        rd(`OFS_STATUS, 32'h0);
        $display("test limit buffer done");
        for (i = 0; i < 2; i = i + 1) begin
            wr(`OFS_CMD, 32'h2);
            wr(`OFS_CTRL, i ? 32'h00000003 : 32'h00000013);
            wr(`OFS_LIMIT, 32'hffff);
            wr(`OFS_COUNT, 32'h0);
            wr(`OFS_CMD, 32'h1);
            for (k = 0; k < 4; k = k + 1)
                enc_u.step(1'b1);
            repeat (10) @(posedge clock);
            rd(`OFS_COUNT, i ? 32'h2 : 32'h4);
            for (k = 0; k < 4; k = k + 1)
                enc_u.step(1'b0);
            repeat (10) @(posedge clock);
            rd(`OFS_COUNT, 32'h0);
        end
        $display("test quadrature done");
        // a rising on channel 0 reloads and starts, channel 1 edges clock the count
        for (i = 0; i < 2; i = i + 1) begin
            wr(`OFS_CMD, 32'h2);
            wr(`OFS_CTRL, i ? 32'h00310321 : 32'h00310b00);
            wr(`OFS_LIMIT, i ? 32'h1 : 32'hffff);
            wr(`OFS_COUNT, 32'h9);
            for (k = 0; k < 4; k = k + 1)
                enc_u.step(1'b1);
            repeat (10) @(posedge clock);
            rd(`OFS_COUNT, 32'h1);
            rd(`OFS_STATUS, {30'h0, i[0], 1'b0});
        end
        chk("start", 2, n_start);
        chk("stop", 1, n_stop);
        chk("reload", 2, n_reload);
        chk("capture", 3, n_capt);
        $display("test edge actions done");
        repeat (4) @(posedge clock);
        conclude;
    end
endmodule // updown_timer_counter_core_tb_top
